// File: rtl/qalvd_fmt.sv
// Purpose: per-channel output coding and overdrive clipping
// Assumes: sample arrives as two's complement on the same clock
// Notes: one register stage; result is replaced every clock, whether or not the serializer loads it
`timescale 1ns/1ns
`default_nettype none
module qalvd_fmt (
	input wire logic clk_i, // system clock
	input wire logic rst_n_i, // synchronised reset, active low
	input wire qalvd_pkg::qalvd_samp_t samp_i, // raw sample and overdrive flags
	input wire logic offset_bin_i, // select offset binary coding
	output logic [13:0] code_o // coded sample
);
	import qalvd_pkg::*;

	// coding and clipping; overdrive outranks the sample value
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			code_o <= 14'h0000;
		end else if (samp_i.over_pos) begin
			code_o <= offset_bin_i ? FS_POS_OB : FS_POS_TC; // RULE_15
		end else if (samp_i.over_neg) begin
			code_o <= offset_bin_i ? FS_NEG_OB : FS_NEG_TC; // RULE_16
		end else if (offset_bin_i) begin
			code_o <= {~samp_i.code[13], samp_i.code[12:0]}; // RULE_14
		end else begin
			code_o <= samp_i.code; // RULE_14
		end
	end

	a_clip_pos: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_15
		samp_i.over_pos |=> code_o == ($past(offset_bin_i) ? FS_POS_OB : FS_POS_TC))
		else $error("positive overdrive not clipped to full scale");

	a_clip_neg: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_16
		samp_i.over_neg && !samp_i.over_pos |=> code_o == ($past(offset_bin_i) ? FS_NEG_OB : FS_NEG_TC))
		else $error("negative overdrive not clipped to full scale");

endmodule // qalvd_fmt
`default_nettype wire

// File: rtl/qalvd_pkg.sv
// Purpose: shared constants and types for the quad-channel serial lane formatter
// Assumes: one 10 MHz clock; registers on a plain strobe port, word aligned
// Notes: every offset, field position, reset value and code lives here once
package qalvd_pkg;

	// register byte addresses
	localparam logic [7:0] OFS_CTRL = 8'h00; // enable, config source, lane config
	localparam logic [7:0] OFS_DRIVE = 8'h04; // driver current settings
	localparam logic [7:0] OFS_TERM = 8'h08; // termination selections
	localparam logic [7:0] OFS_STATUS = 8'h0C; // live state, read only

	// field positions
	localparam int POS_EN = 0; // ctrl: serializer running
	localparam int POS_PINS = 1; // ctrl: take lane config from the pins
	localparam int POS_CFG = 8; // ctrl: lane config, seven bits
	localparam int POS_DOUBLE = 2; // drive: current doubling
	localparam int POS_TERM_DATA = 8; // term: data driver selections
	localparam int POS_FCNT = 16; // status: frame counter

	// reset values: running, single lane, 14x, msb first, two's complement
	localparam logic [31:0] RST_CTRL = 32'h0000_0001;
	localparam logic [31:0] RST_DRIVE = 32'h0000_0000;
	localparam logic [31:0] RST_TERM = 32'h0000_0000;

	// driver current codes
	localparam logic [1:0] CUR_3P5MA = 2'h0; // default
	localparam logic [1:0] CUR_2P5MA = 2'h1;
	localparam logic [1:0] CUR_3P0MA = 2'h2;
	localparam logic [1:0] CUR_4P5MA = 2'h3;

	// full-scale codes for overdrive
	localparam logic [13:0] FS_POS_OB = 14'h3FFF;
	localparam logic [13:0] FS_POS_TC = 14'h1FFF;
	localparam logic [13:0] FS_NEG_OB = 14'h0000;
	localparam logic [13:0] FS_NEG_TC = 14'h2000;

	// serial word lengths per lane
	localparam logic [4:0] BITS_1L_14 = 5'h0E;
	localparam logic [4:0] BITS_1L_16 = 5'h10;
	localparam logic [4:0] BITS_2L_14 = 5'h07;
	localparam logic [4:0] BITS_2L_16 = 5'h08;

	// two-lane bit ordering
	typedef enum logic [1:0] {
		ORD_BYTE = 2'h0, // lane0 low half, lane1 high half
		ORD_BIT = 2'h1, // lane0 even bits, lane1 odd bits
		ORD_WORD = 2'h2 // whole words alternate lanes
	} qalvd_order_t;

	// serializer state, gray along hold -> run
	typedef enum logic [0:0] {
		ST_HOLD = 1'h0,
		ST_RUN = 1'h1
	} qalvd_state_t;

	// lane configuration, seven bits
	typedef struct packed {
		logic two_lane; // two lanes per channel
		logic ser16; // 16x serialization
		logic sdr; // single data rate bit clock, two lanes only
		qalvd_order_t order; // two-lane bit order
		logic lsb_first; // shift lsb first
		logic offset_bin; // offset binary coding
	} qalvd_cfg_t;

	// one converter sample with its overdrive flags
	typedef struct packed {
		logic [13:0] code; // two's complement sample
		logic over_pos; // positive overdrive
		logic over_neg; // negative overdrive
	} qalvd_samp_t;

endpackage

// File: rtl/qalvd_top.sv
// Purpose: quad-channel sample serializer with bit clock and frame clock outputs
// Assumes: clk_i is the sampling-derived serializer clock; one lane bit per cycle in DDR
// Notes: lane configuration changes take effect only at a frame boundary
//
// How it works
// RULE_01: single lane sends bits on both clock edges
// RULE_02: new word at each frame rise, msb first
// RULE_03: single lane rate is 14x or 16x
// RULE_04: 16x two-lane pads two zeros, eight per lane
// RULE_05: 16x two-lane supports DDR or SDR bit clock
// RULE_06: 16x frame at sample rate, half for words
// RULE_07: 14x frame full for SDR, half for DDR
// RULE_08: 14x two-lane sends seven bits per lane
// RULE_09: byte order: lane0 low seven, lane1 high
// RULE_10: bit order: lane0 even bits, lane1 odd
// RULE_11: word order alternates whole samples between lanes; in 14x SDR only lane 0 is reloaded, once per frame
// RULE_12: msb first after reset, lsb first selectable
// RULE_13: two-lane lsb first reverses within each lane
// RULE_14: two's complement default, offset binary selectable
// RULE_15: positive overdrive gives positive full scale
// RULE_16: negative overdrive gives negative full scale
// RULE_17: driver current select and doubling settings
// RULE_18: separate five-bit termination for clock, data
// RULE_19: config from pins or from registers
// RULE_20: host uses two-lane DDR above 65 MSPS
// RULE_21: receiver captures with the sent bit clock
// RULE_22: load at frame boundary, shift without gaps
// RULE_23: clocks derived from the serializer clock
`timescale 1ns/1ns
`default_nettype none
module qalvd_top (
	input wire logic clk_i, // 10 MHz clock
	input wire logic resetn_i, // asynchronous reset, active low
	input wire logic [7:0] addr_i, // register byte address
	input wire logic [31:0] wdata_i, // register write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [31:0] rdata_o, // read data, cycle after rd_i
	input wire qalvd_pkg::qalvd_samp_t samp_a_i, // channel a sample
	input wire qalvd_pkg::qalvd_samp_t samp_b_i, // channel b sample
	input wire qalvd_pkg::qalvd_samp_t samp_c_i, // channel c sample
	input wire qalvd_pkg::qalvd_samp_t samp_d_i, // channel d sample
	input wire qalvd_pkg::qalvd_cfg_t cfg_pins_i, // lane config strap pins
	output logic samp_take_o, // pulse: samples taken this cycle
	output logic chan_a_lane0_o, // channel a lane 0
	output logic chan_a_lane1_o, // channel a lane 1
	output logic chan_b_lane0_o, // channel b lane 0
	output logic chan_b_lane1_o, // channel b lane 1
	output logic chan_c_lane0_o, // channel c lane 0
	output logic chan_c_lane1_o, // channel c lane 1
	output logic chan_d_lane0_o, // channel d lane 0
	output logic chan_d_lane1_o, // channel d lane 1
	output logic bit_clock_out_o, // bit clock
	output logic frame_clock_o, // frame clock
	output logic [1:0] driver_current_select_o, // driver current code
	output logic driver_current_double_o, // driver current doubling
	output logic [4:0] term_clk_sel_o, // clock driver termination picks
	output logic [4:0] term_data_sel_o // data driver termination picks
);
	import qalvd_pkg::*;

	// per-lane bit count for one sample
	function automatic logic [4:0] lane_bits(input qalvd_cfg_t c);
		if (!c.two_lane) begin
			lane_bits = c.ser16 ? BITS_1L_16 : BITS_1L_14; // RULE_03
		end else begin
			lane_bits = c.ser16 ? BITS_2L_16 : BITS_2L_14; // RULE_04 RULE_08
		end
	endfunction

	// single lane always runs a DDR bit clock
	function automatic logic sdr_eff(input qalvd_cfg_t c);
		sdr_eff = c.two_lane & c.sdr; // RULE_01 RULE_05
	endfunction

	// clock cycles per sample
	function automatic logic [5:0] samp_cycles(input qalvd_cfg_t c);
		samp_cycles = sdr_eff(c) ? {lane_bits(c), 1'b0} : {1'b0, lane_bits(c)};
	endfunction

	// frame period: one sample, or two where the frame runs at half rate
	function automatic logic half_rate(input qalvd_cfg_t c);
		half_rate = c.two_lane && (c.ser16 ? (c.order == ORD_WORD) : !c.sdr); // RULE_06 RULE_07
	endfunction

	// left-aligned shift image for one lane; first bit to send sits at bit 15
	function automatic logic [15:0] lane_img(input logic [13:0] d, input qalvd_cfg_t c, input logic lane);
		logic [15:0] w16;
		int n;
		int k;
		int p;
		int idx;
		w16 = {2'b00, d}; // RULE_04
		lane_img = 16'h0000;
		if (!c.two_lane || c.order == ORD_WORD) begin
			n = c.ser16 ? 16 : 14; // RULE_11
		end else begin
			n = int'(lane_bits(c));
		end
		for (k = 0; k < 16; k++) begin
			if (k < n) begin
				p = c.lsb_first ? (n - 1 - k) : k; // RULE_12 RULE_13
				if (!c.two_lane || c.order == ORD_WORD) begin
					idx = n - 1 - p; // RULE_02
				end else if (c.order == ORD_BIT) begin
					idx = 2 * (n - 1 - p) + int'(lane); // RULE_10
				end else begin
					idx = int'(lane) * n + (n - 1 - p); // RULE_09
				end
				lane_img[15 - k] = w16[idx[3:0]];
			end
		end
	endfunction

	// reset release through two flip-flops
	logic rst_s1_r;
	logic rst_n;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	// registers
	logic [31:0] ctrl_r; // enable, source, lane config
	logic [31:0] drive_r; // current settings
	logic [31:0] term_r; // termination picks
	qalvd_cfg_t cfg_reg; // lane config field of ctrl
	assign cfg_reg = qalvd_cfg_t'(ctrl_r[POS_CFG +: 7]);

	// register writes; unmapped addresses are ignored
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= RST_CTRL;
			drive_r <= RST_DRIVE;
			term_r <= RST_TERM;
		end else if (wr_i) begin
			if (addr_i == OFS_CTRL) begin
				ctrl_r <= wdata_i & 32'h0000_7F03;
			end else if (addr_i == OFS_DRIVE) begin
				drive_r <= wdata_i & 32'h0000_0007; // RULE_17
			end else if (addr_i == OFS_TERM) begin
				term_r <= wdata_i & 32'h0000_1F1F; // RULE_18
			end
		end
	end

	// driver settings leave straight from their register bits
	assign driver_current_select_o = drive_r[1:0]; // RULE_17
	assign driver_current_double_o = drive_r[POS_DOUBLE]; // RULE_17
	assign term_clk_sel_o = term_r[4:0]; // RULE_18
	assign term_data_sel_o = term_r[POS_TERM_DATA +: 5]; // RULE_18

	// strap pins come from outside: three stages, accepted once stages two and three agree
	qalvd_cfg_t pin_s1_r;
	qalvd_cfg_t pin_s2_r;
	qalvd_cfg_t pin_s3_r;
	qalvd_cfg_t pin_cfg_r;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r <= qalvd_cfg_t'(7'h00);
			pin_s2_r <= qalvd_cfg_t'(7'h00);
			pin_s3_r <= qalvd_cfg_t'(7'h00);
			pin_cfg_r <= qalvd_cfg_t'(7'h00);
		end else begin
			pin_s1_r <= cfg_pins_i;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			if (pin_s2_r == pin_s3_r) begin
				pin_cfg_r <= pin_s3_r;
			end
		end
	end

	// configuration source select
	qalvd_cfg_t cfg_sel;
	assign cfg_sel = ctrl_r[POS_PINS] ? pin_cfg_r : cfg_reg; // RULE_19

	// serializer state and timing
	qalvd_state_t state_r;
	qalvd_cfg_t cfg_act_r; // config in force for this frame
	logic [5:0] cyc_r; // cycle within frame
	logic [5:0] scyc; // cycles per sample
	logic [5:0] fcyc; // cycles per frame
	logic run;
	logic ld; // sample boundary
	logic step; // shift strobe
	logic samp_par_r; // sample parity for word order
	logic [15:0] frame_cnt_r; // frames sent
	logic [5:0] ld_gap_r; // cycles since the last load, checker helper
	assign run = (state_r == ST_RUN);
	assign scyc = samp_cycles(cfg_act_r);
	assign fcyc = half_rate(cfg_act_r) ? {scyc[4:0], 1'b0} : scyc;
	assign ld = run && (cyc_r == 6'h00 || cyc_r == scyc); // RULE_22
	// sdr holds each bit over a low then a high bit clock cycle, so shift after the high one
	assign step = run && (!sdr_eff(cfg_act_r) || !cyc_r[0]); // RULE_22

	// state: hold while disabled; config is only swapped in hold or at frame end so no word is torn
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_HOLD;
			cfg_act_r <= qalvd_cfg_t'(7'h00);
			cyc_r <= 6'h00;
		end else begin
			case (state_r)
				ST_HOLD: begin
					cfg_act_r <= cfg_sel;
					cyc_r <= 6'h00;
					if (ctrl_r[POS_EN]) begin
						state_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (cyc_r == fcyc - 6'h01) begin
						cyc_r <= 6'h00; // RULE_23
						cfg_act_r <= cfg_sel;
						if (!ctrl_r[POS_EN]) begin
							state_r <= ST_HOLD;
						end
					end else begin
						cyc_r <= cyc_r + 6'h01; // RULE_23
					end
				end
				default: begin
					state_r <= ST_HOLD;
				end
			endcase
		end
	end

	// sample parity and frame count
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			samp_par_r <= 1'b0;
			frame_cnt_r <= 16'h0000;
			ld_gap_r <= 6'h00;
		end else if (!run) begin
			samp_par_r <= 1'b0;
		end else begin
			ld_gap_r <= ld ? 6'h00 : ld_gap_r + 6'h01;
			// cleared at frame end so lane 0 always owns the word that starts with the frame rise
			if (cyc_r == fcyc - 6'h01) begin
				samp_par_r <= 1'b0; // RULE_11
			end else if (ld) begin
				samp_par_r <= ~samp_par_r; // RULE_11
			end
			if (cyc_r == 6'h00) begin
				frame_cnt_r <= frame_cnt_r + 16'h0001;
			end
		end
	end

	// per-channel coding
	logic [13:0] code [4];
	qalvd_samp_t samp [4];
	assign samp[0] = samp_a_i;
	assign samp[1] = samp_b_i;
	assign samp[2] = samp_c_i;
	assign samp[3] = samp_d_i;
	for (genvar c = 0; c < 4; c++) begin : g_fmt
		qalvd_fmt u_fmt (
			.clk_i(clk_i),
			.rst_n_i(rst_n),
			.samp_i(samp[c]),
			.offset_bin_i(cfg_act_r.offset_bin),
			.code_o(code[c])
		);
	end

	// lane shifters; in word order only the lane owning this sample reloads
	logic [15:0] sh_r [4][2];
	logic [1:0] ld_lane;
	always_comb begin
		ld_lane = 2'b00;
		if (ld) begin
			if (cfg_act_r.two_lane && cfg_act_r.order == ORD_WORD) begin
				ld_lane = samp_par_r ? 2'b10 : 2'b01; // RULE_11
			end else begin
				ld_lane = 2'b11;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int c = 0; c < 4; c++) begin
				sh_r[c][0] <= 16'h0000;
				sh_r[c][1] <= 16'h0000;
			end
		end else begin
			for (int c = 0; c < 4; c++) begin
				for (int l = 0; l < 2; l++) begin
					if (!run) begin
						sh_r[c][l] <= 16'h0000;
					end else if (ld_lane[l] && (cfg_act_r.two_lane || l == 0)) begin
						sh_r[c][l] <= lane_img(code[c], cfg_act_r, l[0]); // RULE_22
					end else if (step) begin
						sh_r[c][l] <= {sh_r[c][l][14:0], 1'b0}; // RULE_01 RULE_22
					end
				end
			end
		end
	end

	assign chan_a_lane0_o = sh_r[0][0][15];
	assign chan_a_lane1_o = sh_r[0][1][15];
	assign chan_b_lane0_o = sh_r[1][0][15];
	assign chan_b_lane1_o = sh_r[1][1][15];
	assign chan_c_lane0_o = sh_r[2][0][15];
	assign chan_c_lane1_o = sh_r[2][1][15];
	assign chan_d_lane0_o = sh_r[3][0][15];
	assign chan_d_lane1_o = sh_r[3][1][15];

	// bit and frame clocks, registered beside the data; DDR toggles each cycle,
	// SDR rises mid-bit so the far end can capture on the rise
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			bit_clock_out_o <= 1'b0;
			frame_clock_o <= 1'b0;
			samp_take_o <= 1'b0;
		end else begin
			bit_clock_out_o <= run && (sdr_eff(cfg_act_r) ? cyc_r[0] : ~cyc_r[0]); // RULE_05 RULE_23
			frame_clock_o <= run && (cyc_r < {1'b0, fcyc[5:1]}); // RULE_02 RULE_06 RULE_07
			samp_take_o <= ld;
		end
	end

	// read port: data only in the cycle after the strobe, zero elsewhere
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_o <= 32'h0000_0000;
		end else if (!rd_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (addr_i == OFS_CTRL) begin
			rdata_o <= ctrl_r;
		end else if (addr_i == OFS_DRIVE) begin
			rdata_o <= drive_r;
		end else if (addr_i == OFS_TERM) begin
			rdata_o <= term_r;
		end else if (addr_i == OFS_STATUS) begin
			rdata_o <= {frame_cnt_r, 1'b0, cfg_act_r, 7'h00, run};
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	a_ddr_toggle: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE_01
		run && !cfg_act_r.two_lane && $past(run) && $past(cfg_act_r) == cfg_act_r
		##1 run |-> bit_clock_out_o != $past(bit_clock_out_o))
		else $error("single lane bit clock did not toggle every cycle");

	a_frame_load: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE_02
		ld && cyc_r == 6'h00 |=> frame_clock_o && bit_clock_out_o == !sdr_eff($past(cfg_act_r)))
		else $error("frame clock not rising with the new word");

	a_lane_rate: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE_03
		ld && !cfg_act_r.two_lane && !cfg_act_r.ser16 && $past(run) && $past(cfg_act_r) == cfg_act_r
		|-> ld_gap_r == 6'h0D)
		else $error("single lane 14x word length wrong");

	a_pad_zero: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE_04
		ld_lane[1] && cfg_act_r.two_lane && cfg_act_r.ser16 && cfg_act_r.order == ORD_BYTE
		&& !cfg_act_r.lsb_first |=> !chan_a_lane1_o ##1 (!chan_a_lane1_o || sdr_eff(cfg_act_r)))
		else $error("16x pad bits not zero");

	a_sdr_clock: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE_05
		$rose(bit_clock_out_o) && sdr_eff(cfg_act_r) && cyc_r != 6'h00 |=> !bit_clock_out_o ##1 bit_clock_out_o)
		else $error("sdr bit clock period is not two cycles");

	a_frame_half: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE_07
		$rose(frame_clock_o) && cfg_act_r.two_lane && !cfg_act_r.ser16 && !cfg_act_r.sdr
		&& cyc_r == 6'h01 |-> frame_clock_o[*7] ##1 !frame_clock_o)
		else $error("14x ddr frame clock high time wrong");

	a_word_alt: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE_11
		ld_lane == 2'b01 && cfg_act_r.ser16 && !cfg_act_r.sdr && cyc_r == 6'h00 |-> ##8 ld_lane == 2'b10)
		else $error("word order did not alternate lanes");

	a_drive_write: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE_17
		wr_i && addr_i == OFS_DRIVE |=> driver_current_select_o == $past(wdata_i[1:0])
		&& driver_current_double_o == $past(wdata_i[POS_DOUBLE]))
		else $error("driver current setting not updated");

endmodule // qalvd_top
`default_nettype wire

// File: sim/qalvd_rx_model.sv
// Purpose: receiver model that deserializes one channel's two lanes
// Assumes: lanes, bit clock and frame clock are sampled on the system clock
// Notes: a frame is published at the next frame rise, so the first frame after a change is partial
`timescale 1ns/1ns
`default_nettype none
module qalvd_rx_model (
	input wire logic clk_i, // system clock
	input wire logic rst_n_i, // reset, active low
	input wire logic lane0_i, // lane 0 data
	input wire logic lane1_i, // lane 1 data
	input wire logic bclk_i, // sent bit clock
	input wire logic frame_i, // sent frame clock
	input wire logic sdr_i, // take one bit per bit clock period
	output logic [15:0] word0_o, // lane 0 bits of last frame, first bit highest
	output logic [15:0] word1_o, // lane 1 bits of last frame
	output logic [5:0] nbits_o, // bits taken in last frame
	output logic [5:0] ncyc_o, // cycles in last frame
	output logic done_o // pulse: a frame was published
);
	logic frame_q_r; // frame clock one cycle ago
	logic [15:0] sh0_r; // lane 0 shift register
	logic [15:0] sh1_r; // lane 1 shift register
	logic [5:0] cnt_r; // bits so far
	logic [5:0] cyc_r; // cycles so far
	logic cap; // capture point
	// sdr bits are taken while the sent bit clock is high, ddr bits every cycle
	assign cap = !sdr_i || bclk_i;
	// a frame rise publishes the old word and starts a new one
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frame_q_r <= 1'b0;
			sh0_r <= 16'h0000;
			sh1_r <= 16'h0000;
			cnt_r <= 6'h00;
			cyc_r <= 6'h00;
			word0_o <= 16'h0000;
			word1_o <= 16'h0000;
			nbits_o <= 6'h00;
			ncyc_o <= 6'h00;
			done_o <= 1'b0;
		end else begin
			frame_q_r <= frame_i;
			done_o <= 1'b0;
			if (frame_i && !frame_q_r) begin
				word0_o <= sh0_r;
				word1_o <= sh1_r;
				nbits_o <= cnt_r;
				ncyc_o <= cyc_r;
				done_o <= 1'b1;
				sh0_r <= {15'h0000, lane0_i & cap};
				sh1_r <= {15'h0000, lane1_i & cap};
				cnt_r <= {5'h00, cap};
				cyc_r <= 6'h01;
			end else begin
				if (cap) begin
					sh0_r <= {sh0_r[14:0], lane0_i};
					sh1_r <= {sh1_r[14:0], lane1_i};
					cnt_r <= cnt_r + 6'h01;
				end
				cyc_r <= cyc_r + 6'h01;
			end
		end
	end
endmodule // qalvd_rx_model
`default_nettype wire

// File: sim/tb.sv
// Purpose: bench for the quad-channel serial lane formatter
// Assumes: samples held constant, so every frame of one setting carries the same words
// Notes: frames right after a setting change are skipped, since the change waits for a frame end
`timescale 1ns/1ns
`default_nettype none
module tb;
	import qalvd_pkg::*;
	logic clk_i; // 10 MHz, far below the single-lane limit
	logic resetn_i; // reset, active low
	logic [7:0] addr_i;
	logic [31:0] wdata_i;
	logic wr_i;
	logic rd_i;
	logic [31:0] rdata_o;
	qalvd_samp_t samp_a_i; // checked on channel a
	qalvd_samp_t samp_d_i; // checked on channel d
	qalvd_cfg_t cfg_pins_i; // strap pins
	logic [7:0] lane_o; // a0 a1 b0 b1 c0 c1 d0 d1
	logic bclk;
	logic frame;
	logic [1:0] cur_sel;
	logic cur_dbl;
	logic [4:0] term_clk;
	logic [4:0] term_data;
	logic [15:0] wa0, wa1, wd0, wd1; // published lane words
	logic [5:0] nba, nca; // bits and cycles of last frame
	logic done_a;
	logic sdr_cap; // receiver capture mode
	int num_errors, compares;
	logic [6:0] cases [15]; // lane settings under test
	logic take; // sample-take pulse
	logic frame_q; // frame clock one cycle ago
	int takes, ntakes; // sample takes in the running and in the last frame
	int bc_bad; // cycles where lanes b and c differ from d and a
	qalvd_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .samp_a_i(samp_a_i), .samp_b_i(samp_d_i), .samp_c_i(samp_a_i), .samp_d_i(samp_d_i),
		.cfg_pins_i(cfg_pins_i), .samp_take_o(take), .chan_a_lane0_o(lane_o[0]), .chan_a_lane1_o(lane_o[1]),
		.chan_b_lane0_o(lane_o[2]), .chan_b_lane1_o(lane_o[3]), .chan_c_lane0_o(lane_o[4]),
		.chan_c_lane1_o(lane_o[5]), .chan_d_lane0_o(lane_o[6]), .chan_d_lane1_o(lane_o[7]),
		.bit_clock_out_o(bclk), .frame_clock_o(frame), .driver_current_select_o(cur_sel),
		.driver_current_double_o(cur_dbl), .term_clk_sel_o(term_clk), .term_data_sel_o(term_data));
	qalvd_rx_model rx_a (.clk_i(clk_i), .rst_n_i(resetn_i), .lane0_i(lane_o[0]), .lane1_i(lane_o[1]), .bclk_i(bclk),
		.frame_i(frame), .sdr_i(sdr_cap), .word0_o(wa0), .word1_o(wa1), .nbits_o(nba), .ncyc_o(nca), .done_o(done_a));
	qalvd_rx_model rx_d (.clk_i(clk_i), .rst_n_i(resetn_i), .lane0_i(lane_o[6]), .lane1_i(lane_o[7]), .bclk_i(bclk),
		.frame_i(frame), .sdr_i(sdr_cap), .word0_o(wd0), .word1_o(wd1), .nbits_o(), .ncyc_o(), .done_o());
	// free-running system clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// count sample takes per frame; b and c carry the same samples as d and a
	always @(posedge clk_i) begin
		frame_q <= frame;
		if (frame && !frame_q) begin
			ntakes <= takes;
			takes <= int'(take);
		end else begin
			takes <= takes + int'(take);
		end
		if (lane_o[5:2] !== {lane_o[1:0], lane_o[7:6]}) bc_bad <= bc_bad + 1;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	// wait for k published frames, bounded
	task automatic frames(input int k);
		int t;
		for (int f = 0; f < k; f++) begin
			for (t = 0; t < 200 && done_a !== 1'b1; t++) @(negedge clk_i);
			if (t == 200) begin
				num_errors++;
				wrap_up();
			end
			@(negedge clk_i);
		end
	endtask
	// expected lane word: coding, clipping, lane split, bit order, repeats per frame
	function automatic logic [15:0] lane_exp(input qalvd_cfg_t c, input qalvd_samp_t s, input int lane, input int nb);
		logic [15:0] w, p, q, v;
		int n, span;
		w = c.offset_bin ? {2'h0, s.code ^ 14'h2000} : {2'h0, s.code};
		if (s.over_pos) w = c.offset_bin ? 16'h3FFF : 16'h1FFF;
		else if (s.over_neg) w = c.offset_bin ? 16'h0000 : 16'h2000;
		n = c.two_lane ? (c.ser16 ? 8 : 7) : (c.ser16 ? 16 : 14);
		span = (c.two_lane && c.order == ORD_WORD) ? 2 * n : n;
		p = 16'h0000;
		for (int i = 0; i < span; i++) begin
			if (!c.two_lane) p[i] = (lane == 0) && w[i];
			else if (c.order == ORD_BYTE) p[i] = w[i + lane * n];
			else if (c.order == ORD_BIT) p[i] = w[2 * i + lane];
			else p[i] = w[i];
		end
		q = p;
		if (c.lsb_first) for (int i = 0; i < span; i++) q[i] = p[span - 1 - i];
		// in word order lane 1 starts its word one sample after the frame rise
		if (c.two_lane && c.order == ORD_WORD && lane == 1) begin
			v = q;
			for (int i = 0; i < span; i++) q[(i + n) % span] = v[i];
		end
		v = 16'h0000;
		for (int r = 0; r < nb / span; r++) v = (v << span) | q;
		return v;
	endfunction
	// cycles per frame: one sample, or two for half-rate frames
	function automatic int frame_exp(input qalvd_cfg_t c);
		int s;
		s = c.two_lane ? (c.ser16 ? 8 : 7) * (c.sdr ? 2 : 1) : (c.ser16 ? 16 : 14);
		return (c.two_lane && (c.ser16 ? c.order == ORD_WORD : !c.sdr)) ? 2 * s : s;
	endfunction
	task automatic run_case(input qalvd_cfg_t c, input logic pins);
		int nb;
		logic [31:0] st;
		wr(OFS_CTRL, {17'h00000, pins ? 7'h00 : c, 6'h00, pins, 1'b1});
		sdr_cap <= c.two_lane & c.sdr;
		frames(4);
		nb = frame_exp(c) / ((c.two_lane && c.sdr) ? 2 : 1);
		check("frame cycles", {26'h0, nca}, frame_exp(c));
		check("frame bits", {26'h0, nba}, nb);
		check("lane a0", {16'h0, wa0}, {16'h0, lane_exp(c, samp_a_i, 0, nb)});
		check("lane a1", {16'h0, wa1}, {16'h0, lane_exp(c, samp_a_i, 1, nb)});
		check("lane d0", {16'h0, wd0}, {16'h0, lane_exp(c, samp_d_i, 0, nb)});
		check("lane d1", {16'h0, wd1}, {16'h0, lane_exp(c, samp_d_i, 1, nb)});
		check("sample takes", ntakes, (c.two_lane && (c.ser16 ? c.order == ORD_WORD : !c.sdr)) ? 2 : 1);
		check("lanes b c", bc_bad, 0);
		rd(OFS_STATUS, st);
		check("active cfg", {25'h0, st[14:8]}, {25'h0, c});
	endtask
	// main sequence
	initial begin
		logic [31:0] v;
		resetn_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		sdr_cap = 1'b0;
		cfg_pins_i = 7'h00;
		samp_a_i = {14'h2C35, 2'h0};
		samp_d_i = {14'h0F96, 2'h0};
		cases = '{7'h00, 7'h20, 7'h03, 7'h22, 7'h60, 7'h70, 7'h64, 7'h6A, 7'h78, 7'h50, 7'h56, 7'h40, 7'h45, 7'h48, 7'h76};
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rd(OFS_CTRL, v);
		check("ctrl reset", v, 32'h0000_0001);
		rd(OFS_DRIVE, v);
		check("drive reset", v, 32'h0);
		rd(OFS_TERM, v);
		check("term reset", v, 32'h0);
		for (int k = 0; k < 15; k++) run_case(cases[k], 1'b0);
		// overdrive both ways in both codings
		for (int k = 0; k < 4; k++) begin
			samp_a_i <= {14'h0123, k[1] ? 2'h2 : 2'h1};
			run_case({6'h00, k[0]}, 1'b0);
		end
		cfg_pins_i <= 7'h64;
		run_case(7'h64, 1'b1);
		// every current code with and without doubling
		for (int k = 0; k < 8; k++) begin
			wr(OFS_DRIVE, 32'(k));
			#1 check("current", {29'h0, cur_dbl, cur_sel}, 32'(k));
		end
		wr(OFS_TERM, 32'h0000_1A05);
		#1 check("term pins", {22'h0, term_data, term_clk}, {22'h0, 5'h1A, 5'h05});
		wr(OFS_DRIVE, 32'hFFFF_FFFF);
		rd(OFS_DRIVE, v);
		check("drive mask", v, 32'h0000_0007);
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10, v);
		check("unmapped", v, 32'h0);
		wrap_up();
	end
endmodule // tb
`default_nettype wire
